/* File: si_map.svh */
`ifndef SI_MAP_SVH
`define SI_MAP_SVH
// Register offset of the control/status word (byte address, one aligned word).
`define SI_CSR_ADDR        4'h0
// Field positions inside the control/status register.
`define SI_BIT_SRC_SEL     7
`define SI_BIT_VIRQ_EN     6
`define SI_BIT_VFLAG       5
`define SI_BIT_LVRST       4
`define SI_BIT_RSVD        3
`define SI_BIT_CG_IRQ_EN   2
`define SI_BIT_CG_SWITCHED 1
`define SI_BIT_WDRST       0
// Reset value of the control/status register.
`define SI_CSR_RESET       8'h00
// Backup oscillator period in ns and in system clock cycles (50 MHz).
`define SI_BACKUP_PERIOD_NS 640
`define SI_CLK_PERIOD_NS    20
`define SI_BACKUP_CYCLES    (`SI_BACKUP_PERIOD_NS / `SI_CLK_PERIOD_NS)
// Width of the backup oscillator period counter.
`define SI_BACKUP_CNT_W     6
`endif

/* File: si_pkg.sv */
package si_pkg;
  // Reset cause reported at reset release.
  typedef enum logic [2:0] {
    CAUSE_PIN      = 3'b001,
    CAUSE_WATCHDOG = 3'b010,
    CAUSE_LOWVOLT  = 3'b100
  } reset_cause_t;
  // Clock guard states, one-hot.
  typedef enum logic [2:0] {
    CG_MAIN   = 3'b001,
    CG_BACKUP = 3'b010,
    CG_HALTED = 3'b100
  } guard_state_t;
endpackage

/* File: si_sync.sv */
`timescale 1ns/1ps
// Two-flop level synchroniser; the first stage feeds only the second.
module si_sync (
  input  wire logic clk,   // System clock.
  input  wire logic rst,   // Asynchronous reset, active high.
  input  wire logic d,     // Asynchronous level.
  output logic      q      // Synchronised level.
);
  logic meta_q;            // First stage, read only by the second.

  // Both stages reset to a constant.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // si_sync

/* File: system_integrity_monitor.sv */
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "si_map.svh"

module system_integrity_monitor (
  input  wire logic        clk,                  // System clock, 50 MHz.
  input  wire logic        rst,                  // Asynchronous reset, active high.
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,          // Byte address.
  input  wire logic        avs_read,             // Read request.
  input  wire logic        avs_write,            // Write request.
  input  wire logic [31:0] avs_writedata,        // Write data.
  input  wire logic [3:0]  avs_byteenable,       // Byte enables.
  output logic [31:0]      avs_readdata,         // Read data.
  output logic             avs_waitrequest,      // Stall until answer is ready.
  // Options and system status.
  input  wire logic        opt_lowvolt_en,       // Low-voltage reset unit option.
  input  wire logic        opt_guard_en,         // Clock guard option.
  input  wire logic        cause_valid,          // Pulse at reset release with cause.
  input  wire logic [1:0]  cause_code,           // 0 pin, 1 watchdog, 2 low voltage.
  input  wire logic        cmp_supply,           // Supply comparator, async.
  input  wire logic        cmp_ext,              // External pin comparator, async.
  input  wire logic        main_clk_edge,        // Main oscillator edge seen (sync).
  input  wire logic        main_clk_spike,       // Main clock glitch detected (sync).
  input  wire logic        halt_mode,            // Full halt active.
  input  wire logic        active_halt_mode,     // Active-halt active.
  input  wire logic        cpu_irq_mask,         // CPU interrupt mask set.
  input  wire logic        volt_irq_ack,         // Service entry for voltage vector.
  output logic             volt_irq,             // Voltage interrupt request.
  output logic             guard_irq,            // Clock guard interrupt request.
  output logic             wake_req,             // Wake-up from wait or halt.
  output logic             backup_clk_sel,       // Backup oscillator selected.
  output logic             main_clk_gate         // Main clock passed by filter.
);
  // ---------------------------------------------------------------
  // Bus access decode
  // ---------------------------------------------------------------
  logic        ack_q;          // One-cycle answer pulse.
  logic        hit;            // Address matches the register.
  logic        rd_stb;         // Accepted read.
  logic        wr_stb;         // Accepted write to low lane.

  // A request is answered in the cycle after it appears.
  assign hit    = (avs_address == `SI_CSR_ADDR);
  assign rd_stb = avs_read && ack_q && hit;
  assign wr_stb = avs_write && ack_q && hit && avs_byteenable[0];

  // Answer generator: waitrequest drops for one cycle per request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_comb begin
    avs_waitrequest = !ack_q;
  end

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  logic src_sel_q;             // Voltage source select.
  logic virq_en_q;             // Voltage interrupt enable.
  logic cg_irq_en_q;           // Clock guard interrupt enable.

  // Software-owned bits; the reserved bit is not stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_sel_q   <= 1'b0;
      virq_en_q   <= 1'b0;
      cg_irq_en_q <= 1'b0;
    end else if (wr_stb) begin
      src_sel_q   <= avs_writedata[`SI_BIT_SRC_SEL];
      virq_en_q   <= avs_writedata[`SI_BIT_VIRQ_EN];
      cg_irq_en_q <= avs_writedata[`SI_BIT_CG_IRQ_EN];
    end
  end

  // ---------------------------------------------------------------
  // Voltage monitor
  // ---------------------------------------------------------------
  logic sup_s;                 // Synchronised supply comparator.
  logic ext_s;                 // Synchronised pin comparator.
  logic vflag_q;               // Voltage detect flag.
  logic vflag_d;               // Next voltage flag.
  logic vpend_q;               // Pending voltage interrupt.

  // Synchronise both comparators before any edge logic looks at them.
  si_sync u_sync_sup (.clk(clk), .rst(rst), .d(cmp_supply), .q(sup_s));
  si_sync u_sync_ext (.clk(clk), .rst(rst), .d(cmp_ext),    .q(ext_s));

  // The monitor runs only with the reset unit enabled; it ignores halt.
  always_comb begin
    if (!opt_lowvolt_en) begin
      vflag_d = 1'b0;
    end else begin
      vflag_d = src_sel_q ? ext_s : sup_s;
    end
  end

  // Flag follows the comparator; software writes do not touch it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vflag_q <= 1'b0;
    end else begin
      vflag_q <= vflag_d;
    end
  end

  // A flag change with the enable set sets the pending bit; a change wins over the ack.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vpend_q <= 1'b0;
    end else if (virq_en_q && (vflag_d != vflag_q)) begin
      vpend_q <= 1'b1;
    end else if (volt_irq_ack || !virq_en_q) begin
      vpend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Clock guard
  // ---------------------------------------------------------------
  si_pkg::guard_state_t         cg_state_q;     // Guard state.
  si_pkg::guard_state_t         cg_resume_q;    // State to resume after halt.
  logic [`SI_BACKUP_CNT_W-1:0]  miss_cnt_q;     // Cycles since last main edge.
  logic                         switched_q;     // Clock-switched flag.
  logic                         cg_on;          // Guard enabled by option.
  logic                         miss;           // Clock missing a full period.

  localparam logic [`SI_BACKUP_CNT_W-1:0] MISS_LIMIT = `SI_BACKUP_CNT_W'(`SI_BACKUP_CYCLES - 1);

  assign cg_on = opt_guard_en;
  assign miss  = (miss_cnt_q == MISS_LIMIT);

  // Count cycles with no main-clock edge; saturates at one backup period.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miss_cnt_q <= '0;
    end else if (main_clk_edge || !cg_on || halt_mode) begin
      miss_cnt_q <= '0;
    end else if (!miss) begin
      miss_cnt_q <= miss_cnt_q + `SI_BACKUP_CNT_W'(1);
    end
  end

  // Guard state machine: halt freezes the guard and later resumes it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cg_state_q  <= si_pkg::CG_MAIN;
      cg_resume_q <= si_pkg::CG_MAIN;
    end else if (!cg_on) begin
      cg_state_q  <= si_pkg::CG_MAIN;
      cg_resume_q <= si_pkg::CG_MAIN;
    end else begin
      unique case (cg_state_q)
        si_pkg::CG_MAIN: begin
          if (halt_mode) begin
            cg_resume_q <= si_pkg::CG_MAIN;
            cg_state_q  <= si_pkg::CG_HALTED;
          end else if (miss) begin
            cg_state_q <= si_pkg::CG_BACKUP;
          end
        end
        si_pkg::CG_BACKUP: begin
          if (halt_mode) begin
            cg_resume_q <= si_pkg::CG_BACKUP;
            cg_state_q  <= si_pkg::CG_HALTED;
          end else if (main_clk_edge) begin
            cg_state_q <= si_pkg::CG_MAIN;
          end
        end
        si_pkg::CG_HALTED: begin
          if (!halt_mode) begin
            cg_state_q <= cg_resume_q;
          end
        end
        default: begin
          cg_state_q <= si_pkg::CG_MAIN;
        end
      endcase
    end
  end

  // Switched flag: set on entry to backup; a read clears it only if the
  // main clock is back. A set in the read cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switched_q <= 1'b0;
    end else if (!cg_on) begin
      switched_q <= 1'b0;
    end else if (cg_state_q == si_pkg::CG_MAIN && miss && !halt_mode) begin
      switched_q <= 1'b1;
    end else if (rd_stb && cg_state_q == si_pkg::CG_MAIN) begin
      switched_q <= 1'b0;
    end
  end

  // Filter and clock selection outputs, registered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backup_clk_sel <= 1'b0;
      main_clk_gate  <= 1'b1;
    end else begin
      backup_clk_sel <= cg_on && (cg_state_q == si_pkg::CG_BACKUP);
      // Spikes are blocked; a dead source stays blocked until it recovers.
      main_clk_gate  <= !cg_on || (!main_clk_spike && cg_state_q == si_pkg::CG_MAIN);
    end
  end

  // ---------------------------------------------------------------
  // Reset cause flags
  // ---------------------------------------------------------------
  logic lvrst_q;               // Low-voltage reset flag.
  logic wdrst_q;               // Watchdog reset flag.
  si_pkg::reset_cause_t cause; // Decoded cause.

  // Decode the cause code into a one-hot cause.
  function automatic si_pkg::reset_cause_t decode_cause(input logic [1:0] c);
    if (c == 2'd2) begin
      decode_cause = si_pkg::CAUSE_LOWVOLT;
    end else if (c == 2'd1) begin
      decode_cause = si_pkg::CAUSE_WATCHDOG;
    end else begin
      decode_cause = si_pkg::CAUSE_PIN;
    end
  endfunction

  assign cause = decode_cause(cause_code);

  // The flags are not reset by rst: they survive the reset they record.
  // The cause is caught after release by a clocked pulse.
  always_ff @(posedge clk) begin
    if (cause_valid && cause == si_pkg::CAUSE_LOWVOLT) begin
      lvrst_q <= 1'b1;
    end else if (wr_stb && !avs_writedata[`SI_BIT_LVRST]) begin
      lvrst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (cause_valid && cause == si_pkg::CAUSE_WATCHDOG) begin
      wdrst_q <= 1'b1;
    end else if (cause_valid && cause == si_pkg::CAUSE_LOWVOLT) begin
      wdrst_q <= 1'b0;
    end else if (cause_valid && cause == si_pkg::CAUSE_PIN && !lvrst_q) begin
      wdrst_q <= 1'b0;
    end else if (wr_stb && !avs_writedata[`SI_BIT_WDRST]) begin
      wdrst_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read data, interrupts and wake-up
  // ---------------------------------------------------------------
  logic [7:0] csr_view;        // Current register image.

  always_comb begin
    csr_view                         = `SI_CSR_RESET;
    csr_view[`SI_BIT_SRC_SEL]        = src_sel_q;
    csr_view[`SI_BIT_VIRQ_EN]        = virq_en_q;
    csr_view[`SI_BIT_VFLAG]          = vflag_q;
    csr_view[`SI_BIT_LVRST]          = lvrst_q;
    csr_view[`SI_BIT_CG_IRQ_EN]      = cg_irq_en_q;
    csr_view[`SI_BIT_CG_SWITCHED]    = switched_q && cg_on;
    csr_view[`SI_BIT_WDRST]          = wdrst_q;
  end

  // Read data is registered and valid in the cycle waitrequest is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= hit ? {24'h00_0000, csr_view} : 32'h0000_0000;
    end
  end

  // Interrupt requests go out only with enable set and the CPU mask cleared; wake_req ignores the mask.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      volt_irq  <= 1'b0;
      guard_irq <= 1'b0;
      wake_req  <= 1'b0;
    end else begin
      volt_irq  <= vpend_q && !cpu_irq_mask;
      guard_irq <= cg_on && cg_irq_en_q && switched_q && !cpu_irq_mask;
      // Both wake from wait; guard wakes only active-halt, not full halt.
      wake_req  <= vpend_q || (cg_on && cg_irq_en_q && switched_q &&
                               (!halt_mode || active_halt_mode));
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_main_lost;
    cg_on && !halt_mode && cg_state_q == si_pkg::CG_MAIN && miss;
  endsequence

  a_switch_on_loss: assert property (@(posedge clk) disable iff (rst)
    s_main_lost |=> cg_state_q == si_pkg::CG_BACKUP) else $error("no switch to backup");
  a_return_on_edge: assert property (@(posedge clk) disable iff (rst)
    cg_on && !halt_mode && cg_state_q == si_pkg::CG_BACKUP && main_clk_edge
    |=> cg_state_q == si_pkg::CG_MAIN) else $error("no return to main");
  a_flag_on_switch: assert property (@(posedge clk) disable iff (rst)
    s_main_lost |=> switched_q) else $error("switched flag not set");
  a_flag_off_guard: assert property (@(posedge clk) disable iff (rst)
    !cg_on |=> !switched_q && !backup_clk_sel) else $error("switched flag seen with guard off");
  a_vflag_follow: assert property (@(posedge clk) disable iff (rst)
    opt_lowvolt_en && $stable(src_sel_q) ##1 opt_lowvolt_en
    |-> vflag_q == $past(src_sel_q ? ext_s : sup_s)) else $error("flag not following comparator");
  a_vchange_pend: assert property (@(posedge clk) disable iff (rst)
    virq_en_q && vflag_d != vflag_q |=> vpend_q ##1 (volt_irq == !$past(cpu_irq_mask))) else $error("change lost");
  a_vmask_block: assert property (@(posedge clk) disable iff (rst)
    cpu_irq_mask |=> !volt_irq && !guard_irq) else $error("irq while masked");
  a_guard_irq_off: assert property (@(posedge clk) disable iff (rst)
    !cg_on |=> !guard_irq) else $error("guard irq with guard off");
  a_ack_clears: assert property (@(posedge clk) disable iff (rst)
    volt_irq_ack && !(virq_en_q && vflag_d != vflag_q) |=> !vpend_q) else $error("ack did not clear");
  a_halt_no_wake: assert property (@(posedge clk) disable iff (rst)
    halt_mode && !active_halt_mode && !vpend_q |=> !wake_req) else $error("guard woke full halt");
endmodule // system_integrity_monitor

/* File: si_far_model.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Far side: main oscillator and the CPU taking the voltage vector.
// -----------------------------------------------------------------
module si_far_model (
  input  wire logic clk,           // System clock.
  input  wire logic rst,           // Reset, active high.
  input  wire logic osc_run,       // Oscillator healthy when high.
  input  wire logic ack_slow,      // Slow service entry when high.
  input  wire logic volt_irq,      // Voltage interrupt request.
  input  wire logic cpu_irq_mask,  // CPU mask, high = masked.
  output logic      main_clk_edge, // Oscillator edge seen.
  output logic      volt_irq_ack   // Service entry pulse.
);
  logic [1:0] div_q;  // Oscillator divider.
  logic [3:0] wait_q; // Service latency count.
  // A healthy oscillator gives an edge every fourth cycle; a dead one none.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q         <= 2'h0;
      main_clk_edge <= 1'b0;
    end else begin
      div_q         <= div_q + 2'h1;
      main_clk_edge <= osc_run && (div_q == 2'h3);
    end
  end
  // The CPU enters the routine only while the request stands unmasked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q       <= 4'h0;
      volt_irq_ack <= 1'b0;
    end else begin
      volt_irq_ack <= 1'b0;
      if (volt_irq && !cpu_irq_mask && !volt_irq_ack) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == (ack_slow ? 4'hC : 4'h2)) begin
          volt_irq_ack <= 1'b1;
          wait_q       <= 4'h0;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule // si_far_model

/* File: system_integrity_monitor_bench.sv */
`timescale 1ns/1ps
module system_integrity_monitor_bench;
  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, cv = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] be = 4'hF;
  logic ahalt = 1'b0;
  logic [31:0] wd = 32'h0000_0000, rdata;
  logic wreq, lv_en = 1'b1, g_en = 1'b1, c_sup = 1'b0, c_ext = 1'b0;
  logic [1:0] code = 2'h0;
  logic edge_s, spike = 1'b0, halt = 1'b0, mask = 1'b0, ack, osc = 1'b1, slow = 1'b0;
  logic v_irq, g_irq, wake, bsel, gate;
  int err_count = 0, compares = 0;
  // A 50 MHz clock.
  always #10 clk = ~clk;
  system_integrity_monitor i_system_integrity_monitor (.clk(clk), .rst(rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .opt_lowvolt_en(lv_en), .opt_guard_en(g_en), .cause_valid(cv), .cause_code(code),
    .cmp_supply(c_sup), .cmp_ext(c_ext), .main_clk_edge(edge_s), .main_clk_spike(spike),
    .halt_mode(halt), .active_halt_mode(ahalt), .cpu_irq_mask(mask), .volt_irq_ack(ack),
    .volt_irq(v_irq), .guard_irq(g_irq), .wake_req(wake), .backup_clk_sel(bsel),
    .main_clk_gate(gate));
  si_far_model i_si_far_model (.clk(clk), .rst(rst), .osc_run(osc), .ack_slow(slow),
    .volt_irq(v_irq), .cpu_irq_mask(mask), .main_clk_edge(edge_s), .volt_irq_ack(ack));
  // -----------------------------------------------------------------
  // Reporting and comparisons
  // -----------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A bounded wait for one output to reach a level; sel picks the output.
  task automatic wait_sig(input int sel, input logic v, input int lim);
    logic s;
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      s = (sel == 0) ? v_irq : (sel == 1) ? g_irq : (sel == 2) ? wake : bsel;
      if (s === v) break;
    end
    chk_reg({7'h00, s}, {7'h00, v});
    if (s !== v) stop_test();
  endtask
  // -----------------------------------------------------------------
  // Bus cycles: hold the request until waitrequest is sampled low.
  // -----------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      err_count++;
      stop_test();
    end
    @(posedge clk); // One idle edge keeps back-to-back calls race free.
  endtask
  task automatic wr_reg(input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, 4'h0, d & 8'hF7, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk_reg(q, exp);
  endtask
  // Reset followed by the cause pulse of the given kind.
  task automatic reset_by(input logic [1:0] c);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst  <= 1'b0;
    cv   <= 1'b1;
    code <= c;
    @(posedge clk);
    cv <= 1'b0;
    @(posedge clk);
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(4'h0, 8'h10);
    wr_reg(8'hC4);
    rd_chk(4'h0, 8'hC4);
    be <= 4'h0;
    wr_reg(8'h00);
    be <= 4'hF;
    rd_chk(4'h0, 8'hC4);
    rd_chk(4'h4, 8'h00);
    wr_reg(8'h00);
    $display("register test done");
  endtask
  task automatic t_volt();
    slow <= 1'b1;
    wr_reg(8'h40);
    c_sup <= 1'b1;
    wait_sig(0, 1'b1, 20);
    rd_chk(4'h0, 8'h60);
    wait_sig(0, 1'b0, 30);
    slow  <= 1'b0;
    c_ext <= 1'b1;
    c_sup <= 1'b0;
    wait_sig(0, 1'b1, 20);
    wait_sig(0, 1'b0, 20);
    rd_chk(4'h0, 8'h40);
    wr_reg(8'hC0);
    repeat (20) @(posedge clk);
    rd_chk(4'h0, 8'hE0);
    mask  <= 1'b1;
    c_ext <= 1'b0;
    repeat (15) @(posedge clk);
    chk_reg({7'h00, v_irq}, 8'h00);
    rd_chk(4'h0, 8'hC0);
    mask <= 1'b0;
    wait_sig(0, 1'b1, 5);
    wait_sig(0, 1'b0, 20);
    $display("voltage test done");
  endtask
  task automatic t_modes();
    wr_reg(8'h40);
    halt  <= 1'b1;
    c_sup <= 1'b1;
    wait_sig(2, 1'b1, 20);
    halt <= 1'b0;
    wait_sig(0, 1'b0, 30);
    c_sup <= 1'b0;
    wait_sig(0, 1'b0, 30);
    lv_en <= 1'b0;
    c_sup <= 1'b1;
    repeat (15) @(posedge clk);
    chk_reg({7'h00, v_irq}, 8'h00);
    rd_chk(4'h0, 8'h40);
    wr_reg(8'h00);
    c_sup <= 1'b0;
    repeat (10) @(posedge clk);
    lv_en <= 1'b1;
    $display("mode test done");
  endtask
  task automatic t_guard();
    wr_reg(8'h04);
    osc <= 1'b0;
    wait_sig(3, 1'b1, 60);
    chk_reg({7'h00, gate}, 8'h00);
    wait_sig(1, 1'b1, 5);
    chk_reg({7'h00, wake}, 8'h01);
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg({7'h00, wake}, 8'h00);
    ahalt <= 1'b1;
    wait_sig(2, 1'b1, 5);
    halt  <= 1'b0;
    ahalt <= 1'b0;
    wait_sig(3, 1'b1, 5);
    rd_chk(4'h0, 8'h06);
    rd_chk(4'h0, 8'h06);
    osc <= 1'b1;
    wait_sig(3, 1'b0, 30);
    rd_chk(4'h0, 8'h06);
    rd_chk(4'h0, 8'h04);
    g_en <= 1'b0;
    osc  <= 1'b0;
    repeat (60) @(posedge clk);
    chk_reg({6'h00, bsel, g_irq}, 8'h00);
    rd_chk(4'h0, 8'h04);
    osc   <= 1'b1;
    g_en  <= 1'b1;
    spike <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg({7'h00, gate}, 8'h00);
    spike <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg({7'h00, gate}, 8'h01);
    $display("clock guard test done");
  endtask
  task automatic t_causes();
    reset_by(2'h2);
    rd_chk(4'h0, 8'h10);
    reset_by(2'h1);
    rd_chk(4'h0, 8'h11);
    reset_by(2'h0);
    rd_chk(4'h0, 8'h11);
    wr_reg(8'h00);
    rd_chk(4'h0, 8'h00);
    reset_by(2'h1);
    rd_chk(4'h0, 8'h01);
    reset_by(2'h2);
    rd_chk(4'h0, 8'h10);
    $display("reset cause test done");
  endtask
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cv   <= 1'b1; // Power-up counts as a low-voltage reset.
    code <= 2'h2;
    @(posedge clk);
    cv <= 1'b0;
    @(posedge clk);
    t_regs();
    t_volt();
    t_modes();
    t_guard();
    t_causes();
    stop_test();
  end
endmodule // system_integrity_monitor_bench
